// *** design/irq_agg_params.svh ***
`ifndef IRQ_AGG_PARAMS_SVH
`define IRQ_AGG_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ADDR_WIDTH          12
`define OFF_PIN_CONFIG      12'h054
`define OFF_STATUS          12'h058
`define OFF_ENABLE          12'h05c

// ---------------------------------------------------------------
// status / enable bit positions
// ---------------------------------------------------------------
`define BIT_SOFTWARE        31
`define BIT_READY           30
`define BIT_TIMESTAMP       29
`define BIT_FABRIC          28
`define BIT_PHY_B           27
`define BIT_PHY_A           26
`define BIT_TIMER_WRAP      19
`define BIT_POWER_EVENT     17
`define BIT_PIN_EVENT       12

// ---------------------------------------------------------------
// pin configuration bit positions
// ---------------------------------------------------------------
`define BIT_CFG_GLOBAL      12
`define BIT_CFG_GATE        8
`define BIT_CFG_POLARITY    4
`define BIT_CFG_PUSH_PULL   0

// ---------------------------------------------------------------
// masks and reset values
// ---------------------------------------------------------------
`define MASK_DEFINED        32'hfc0a1000
`define MASK_W1C            32'hc00a0000
`define RESET_ENABLE        32'h00000000
`define RESET_STATUS        32'h00000000
`define RESET_RDATA         32'h00000000
`define NUM_STICKY          4

`endif

// *** design/irq_agg_pkg.sv ***
package irq_agg_pkg;

  // internal interrupt sources, all on the system clock
  typedef struct packed {
    logic timestamp_pending;
    logic fabric_pending;
    logic phy_b_pending;
    logic phy_a_pending;
    logic pin_event_pending;
    logic timer_wrap;
    logic power_event;
    logic power_clear_ok;
    logic device_ready;
  } source_type;

  typedef struct packed {
    logic gate;
    logic output_pin_polarity;
    logic push_pull;
  } pin_cfg_type;

endpackage

// *** design/sticky_flag.sv ***
`timescale 1ns/10ps
`default_nettype none

module sticky_flag (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic set,
  input  wire logic clear,
  input  wire logic clear_ok,
  output var  logic flag
);

  logic next_flag;

  // set beats a simultaneous clear so no event is lost
  always_comb begin
    next_flag = flag;
    if (clear && clear_ok) begin
      next_flag = 1'b0;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (clk_en) begin
      flag <= next_flag;
    end
  end

endmodule

`default_nettype wire

// *** design/irq_pin_driver.sv ***
`timescale 1ns/10ps
`default_nettype none

module irq_pin_driver
  import irq_agg_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        request,
  input  wire pin_cfg_type cfg,
  output var  logic        irq_out,
  output var  logic        irq_oe_n
);

  logic active;
  logic next_out;
  logic next_oe_n;

  always_comb begin
    active = request && cfg.gate;
    if (cfg.push_pull) begin
      next_oe_n = 1'b0;
      next_out  = cfg.output_pin_polarity ? active : !active;
    end else begin
      // open drain ignores polarity: pull low or release
      next_oe_n = !active;
      next_out  = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_out  <= 1'b0;
      irq_oe_n <= 1'b1;
    end else if (clk_en) begin
      irq_out  <= next_out;
      irq_oe_n <= next_oe_n;
    end
  end

endmodule

`default_nettype wire

// *** design/top_level_interrupt_aggregator.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "irq_agg_params.svh"

module top_level_interrupt_aggregator
  import irq_agg_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire logic [`ADDR_WIDTH-1:0] address,
  input  wire logic [31:0]            wdata,
  input  wire logic                   write_strobe,
  input  wire logic                   read_strobe,
  output var  logic [31:0]            rdata,
  input  wire source_type             sources,
  input  wire logic                   deassert_hold,
  output var  logic                   global_irq,
  output var  logic                   irq_out,
  output var  logic                   irq_oe_n
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [31:0] interrupt_enable;
  pin_cfg_type pin_cfg;
  logic        ready_seen;
  logic [31:0] next_enable;
  pin_cfg_type next_pin_cfg;
  logic        next_ready_seen;
  logic [31:0] next_rdata;
  logic        next_global;

  logic        status_write;
  logic        enable_write;
  logic        config_write;
  logic [31:0] interrupt_status;
  logic [31:0] pending;
  logic        pin_request;

  // one comparator shared by the write decode, the read mux and the checks
  function automatic logic hit(input logic [`ADDR_WIDTH-1:0] a, input logic [`ADDR_WIDTH-1:0] off);
    hit = (a == off);
  endfunction

  always_comb begin
    status_write = write_strobe && hit(address, `OFF_STATUS);
    enable_write = write_strobe && hit(address, `OFF_ENABLE);
    config_write = write_strobe && hit(address, `OFF_PIN_CONFIG);
  end

  // ---------------------------------------------------------------
  // sticky flags: software, ready, timer wrap, power event
  // ---------------------------------------------------------------
  logic [`NUM_STICKY-1:0] sticky_set;
  logic [`NUM_STICKY-1:0] sticky_clear;
  logic [`NUM_STICKY-1:0] sticky_ok;
  logic [`NUM_STICKY-1:0] sticky;

  always_comb begin
    sticky_set[0]   = interrupt_enable[`BIT_SOFTWARE];
    sticky_clear[0] = status_write && wdata[`BIT_SOFTWARE];
    sticky_ok[0]    = 1'b1;
    // ready flag fires once on the first ready after reset
    sticky_set[1]   = sources.device_ready && !ready_seen;
    sticky_clear[1] = status_write && wdata[`BIT_READY];
    sticky_ok[1]    = 1'b1;
    sticky_set[2]   = sources.timer_wrap;
    sticky_clear[2] = status_write && wdata[`BIT_TIMER_WRAP];
    sticky_ok[2]    = 1'b1;
    sticky_set[3]   = sources.power_event;
    sticky_clear[3] = status_write && wdata[`BIT_POWER_EVENT];
    // clear ignored while unmasked power control flags remain
    sticky_ok[3]    = sources.power_clear_ok;
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_STICKY; g++) begin : g_flag
      sticky_flag u_flag (
        .clock    (clock),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .set      (sticky_set[g]),
        .clear    (sticky_clear[g]),
        .clear_ok (sticky_ok[g]),
        .flag     (sticky[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // status word and aggregation
  // ---------------------------------------------------------------
  // mirrored bits are live levels; only the four sticky bits hold state
  always_comb begin
    interrupt_status                  = `RESET_STATUS;
    interrupt_status[`BIT_SOFTWARE]   = sticky[0];
    interrupt_status[`BIT_READY]      = sticky[1];
    interrupt_status[`BIT_TIMESTAMP]  = sources.timestamp_pending;
    interrupt_status[`BIT_FABRIC]     = sources.fabric_pending;
    interrupt_status[`BIT_PHY_B]      = sources.phy_b_pending;
    interrupt_status[`BIT_PHY_A]      = sources.phy_a_pending;
    interrupt_status[`BIT_TIMER_WRAP] = sticky[2];
    interrupt_status[`BIT_POWER_EVENT] = sticky[3];
    interrupt_status[`BIT_PIN_EVENT]  = sources.pin_event_pending;
    pending = interrupt_status & interrupt_enable;
    next_global = |pending;
    // the hold window masks every source but power management at the pin; global_irq still sees all
    if (deassert_hold) begin
      pin_request = pending[`BIT_POWER_EVENT];
    end else begin
      pin_request = |pending;
    end
  end

  // ---------------------------------------------------------------
  // register writes and read path
  // ---------------------------------------------------------------
  always_comb begin
    next_enable     = interrupt_enable;
    next_pin_cfg    = pin_cfg;
    // latched so a ready level held high raises the flag only once
    next_ready_seen = ready_seen || sources.device_ready;
    next_rdata      = `RESET_RDATA;
    if (enable_write) begin
      next_enable = wdata & `MASK_DEFINED;
    end
    if (config_write) begin
      next_pin_cfg.gate                = wdata[`BIT_CFG_GATE];
      next_pin_cfg.output_pin_polarity = wdata[`BIT_CFG_POLARITY];
      next_pin_cfg.push_pull           = wdata[`BIT_CFG_PUSH_PULL];
    end
    if (read_strobe) begin
      if (hit(address, `OFF_STATUS)) begin
        next_rdata = interrupt_status;
      end else if (hit(address, `OFF_ENABLE)) begin
        next_rdata = interrupt_enable;
      end else if (hit(address, `OFF_PIN_CONFIG)) begin
        next_rdata[`BIT_CFG_GLOBAL]    = global_irq;
        next_rdata[`BIT_CFG_GATE]      = pin_cfg.gate;
        next_rdata[`BIT_CFG_POLARITY]  = pin_cfg.output_pin_polarity;
        next_rdata[`BIT_CFG_PUSH_PULL] = pin_cfg.push_pull;
      end else begin
        next_rdata = `RESET_RDATA;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interrupt_enable <= `RESET_ENABLE;
      pin_cfg          <= '0;
      ready_seen       <= 1'b0;
      rdata            <= `RESET_RDATA;
      global_irq       <= 1'b0;
    end else if (clk_en) begin
      interrupt_enable <= next_enable;
      pin_cfg          <= next_pin_cfg;
      ready_seen       <= next_ready_seen;
      rdata            <= next_rdata;
      global_irq       <= next_global;
    end
  end

  // ---------------------------------------------------------------
  // pin output stage
  // ---------------------------------------------------------------
  // the pin is a flop after the request, so it trails the status word by one edge
  irq_pin_driver u_pin (
    .clock    (clock),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .request  (pin_request),
    .cfg      (pin_cfg),
    .irq_out  (irq_out),
    .irq_oe_n (irq_oe_n)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // sources share the clock, so a read is checked against the source levels one edge back
  // every check but the reset and freeze checks needs clk_en, since a frozen edge moves no state
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_enable_reset_zero: assert property ($rose(rst_n) |-> interrupt_enable == 32'h00000000)
    else $error("enable not zero after reset");

  a_reserved_read_zero: assert property (clk_en && read_strobe && hit(address, `OFF_ENABLE)
    |=> (rdata & ~`MASK_DEFINED) == 32'h00000000)
    else $error("reserved enable bits read nonzero");

  a_software_flag_set: assert property (clk_en && interrupt_enable[`BIT_SOFTWARE]
    |=> interrupt_status[`BIT_SOFTWARE])
    else $error("software flag not set while enabled");

  a_software_flag_idle: assert property (clk_en && !interrupt_enable[`BIT_SOFTWARE]
    && !interrupt_status[`BIT_SOFTWARE] |=> !interrupt_status[`BIT_SOFTWARE])
    else $error("software flag set while disabled");

  a_write_zero_keeps: assert property (clk_en && status_write && !wdata[`BIT_TIMER_WRAP]
    && interrupt_status[`BIT_TIMER_WRAP] |=> interrupt_status[`BIT_TIMER_WRAP])
    else $error("timer flag lost on write of zero");

  a_timer_wrap_set: assert property (clk_en && sources.timer_wrap
    |=> interrupt_status[`BIT_TIMER_WRAP] [*1])
    else $error("timer wrap flag not set");

  a_power_clear_held: assert property (clk_en && status_write && wdata[`BIT_POWER_EVENT]
    && !sources.power_clear_ok && interrupt_status[`BIT_POWER_EVENT]
    |=> interrupt_status[`BIT_POWER_EVENT])
    else $error("power flag cleared before control flags");

  a_global_follows: assert property (clk_en
    |=> global_irq == |$past(pending))
    else $error("global indication wrong");

  a_power_not_held: assert property (clk_en && deassert_hold && pending[`BIT_POWER_EVENT]
    && pin_cfg.gate && pin_cfg.push_pull && pin_cfg.output_pin_polarity |=> irq_out)
    else $error("power source held off by interval");

  a_gate_blocks_pin: assert property (clk_en && !pin_cfg.gate && pin_cfg.push_pull
    |=> irq_out == !$past(pin_cfg.output_pin_polarity))
    else $error("pin asserted with gate clear");

  a_open_drain_low: assert property (clk_en && !pin_cfg.push_pull
    |=> irq_out == 1'b0 && irq_oe_n == !($past(pin_request) && $past(pin_cfg.gate)))
    else $error("open drain pin misdriven");

  a_ready_flag_set: assert property (clk_en && sources.device_ready && !ready_seen
    |=> interrupt_status[`BIT_READY])
    else $error("ready flag not set");

  a_timestamp_mirror: assert property (clk_en && read_strobe && hit(address, `OFF_STATUS)
    |=> rdata[`BIT_TIMESTAMP] == $past(sources.timestamp_pending))
    else $error("timestamp bit does not mirror source");

  a_fabric_mirror: assert property (clk_en && read_strobe && hit(address, `OFF_STATUS)
    |=> rdata[`BIT_FABRIC] == $past(sources.fabric_pending))
    else $error("fabric bit does not mirror source");

  a_phy_b_mirror: assert property (clk_en && read_strobe && hit(address, `OFF_STATUS)
    |=> rdata[`BIT_PHY_B] == $past(sources.phy_b_pending))
    else $error("second phy bit does not mirror source");

  a_phy_a_mirror: assert property (clk_en && read_strobe && hit(address, `OFF_STATUS)
    |=> rdata[`BIT_PHY_A] == $past(sources.phy_a_pending))
    else $error("first phy bit does not mirror source");

  a_pin_event_mirror: assert property (clk_en && read_strobe && hit(address, `OFF_STATUS)
    |=> rdata[`BIT_PIN_EVENT] == $past(sources.pin_event_pending))
    else $error("pin event bit does not mirror source");

  a_status_reserved_zero: assert property (clk_en && read_strobe && hit(address, `OFF_STATUS)
    |=> (rdata & ~`MASK_DEFINED) == 32'h00000000)
    else $error("reserved status bits read nonzero");

  a_enable_write_lands: assert property (clk_en && enable_write
    |=> interrupt_enable == ($past(wdata) & `MASK_DEFINED))
    else $error("enable write did not land");

  a_enable_frozen: assert property (!clk_en
    |=> interrupt_enable == $past(interrupt_enable))
    else $error("enable changed while clock enable low");

  a_power_clear_lands: assert property (clk_en && status_write && wdata[`BIT_POWER_EVENT]
    && sources.power_clear_ok && !sources.power_event |=> !interrupt_status[`BIT_POWER_EVENT])
    else $error("power flag not cleared when allowed");

  a_timer_clear_lands: assert property (clk_en && status_write && wdata[`BIT_TIMER_WRAP]
    && !sources.timer_wrap |=> !interrupt_status[`BIT_TIMER_WRAP])
    else $error("timer flag not cleared by write of one");

  a_enable_masks_pin: assert property (clk_en && pin_cfg.gate && pin_cfg.push_pull
    && pin_cfg.output_pin_polarity && pending == 32'h00000000 |=> !irq_out)
    else $error("pin asserted with no enabled source");

  a_push_pull_level: assert property (clk_en && pin_cfg.push_pull && pin_cfg.gate
    |=> !irq_oe_n && irq_out == ($past(pin_cfg.output_pin_polarity) ~^ $past(pin_request)))
    else $error("push pull pin level wrong");

endmodule

`default_nettype wire

// *** test/irq_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// host side of the interrupt pin, board pull-up included
// ---------------------------------------------------------------
module irq_host_model (
  input  wire logic irq_out,
  input  wire logic irq_oe_n,
  output wire logic pin_level
);
  // a released pin settles to the pull-up, never to a stale driven value
  assign pin_level = irq_oe_n ? 1'b1 : irq_out;
endmodule

`default_nettype wire

// *** test/top_level_interrupt_aggregator_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "irq_agg_params.svh"

module top_level_interrupt_aggregator_tb
  import irq_agg_pkg::*;
;
  logic                   clock = 1'b0;
  logic                   rst_n, clk_en, write_strobe, read_strobe, deassert_hold;
  logic                   rd_seen = 1'b0;
  logic [`ADDR_WIDTH-1:0] address;
  logic [31:0]            wdata, rdata, r;
  logic [31:0]            exp_q[$];
  logic [31:0]            cfg_tab[5];
  source_type             sources;
  logic                   global_irq, irq_out, irq_oe_n, pin_level;
  int                     error_cnt = 0;
  int                     num_checks = 0;
  int                     cycles = 0;

  always #20 clock = ~clock;

  top_level_interrupt_aggregator dut_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .address(address),
    .wdata(wdata), .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata), .sources(sources),
    .deassert_hold(deassert_hold), .global_irq(global_irq), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
  irq_host_model host_u (.irq_out(irq_out), .irq_oe_n(irq_oe_n), .pin_level(pin_level));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic exp_pin(input logic [31:0] c, input logic act);
    logic a;
    a = act & c[`BIT_CFG_GATE];
    return c[`BIT_CFG_PUSH_PULL] ? (c[`BIT_CFG_POLARITY] ? a : !a) : !a;
  endfunction

  // ---------------------------------------------------------------
  // register bus master
  // ---------------------------------------------------------------
  task automatic wr(input logic [`ADDR_WIDTH-1:0] a, input logic [31:0] d);
    @(posedge clock);
    address      <= a;
    wdata        <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  task automatic rd(input logic [`ADDR_WIDTH-1:0] a, input logic [31:0] e);
    @(posedge clock);
    address     <= a;
    read_strobe <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    read_strobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample exactly there
  always @(posedge clock) begin
    cycles  <= cycles + 1;
    rd_seen <= read_strobe;
    if (rd_seen && exp_q.size() > 0)
      check("rdata", rdata, exp_q.pop_front());
    // whole run needs under two hundred cycles
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    rst_n         = 1'b0;
    clk_en        = 1'b1;
    address       = '0;
    wdata         = '0;
    write_strobe  = 1'b0;
    read_strobe   = 1'b0;
    deassert_hold = 1'b0;
    sources       = '0;
    cfg_tab       = '{32'h000, 32'h100, 32'h101, 32'h111, 32'h011};
    r = $urandom(98004);
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(`OFF_STATUS, `RESET_STATUS);
    rd(`OFF_ENABLE, `RESET_ENABLE);
    rd(`OFF_PIN_CONFIG, 32'h0);
    wr(`OFF_ENABLE, 32'hffffffff);
    rd(`OFF_ENABLE, `MASK_DEFINED);
    rd(`OFF_STATUS, 32'h80000000);
    rd(12'h100, 32'h0);
    wr(`OFF_ENABLE, 32'h0);
    rd(`OFF_STATUS, 32'h80000000);
    wr(`OFF_STATUS, 32'h80000000);
    rd(`OFF_STATUS, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      @(posedge clock) sources <= source_type'({r[4:0], 4'h0});
      rd(`OFF_STATUS, (32'(r[4:1]) << 26) | (32'(r[0]) << 12));
    end
    @(posedge clock) sources <= '0;
    $display("test mirrors done");
    @(posedge clock) sources.timer_wrap <= 1'b1;
    @(posedge clock) sources.timer_wrap <= 1'b0;
    rd(`OFF_STATUS, 32'h00080000);
    wr(`OFF_STATUS, 32'h7ff7ffff);
    rd(`OFF_STATUS, 32'h00080000);
    wr(`OFF_STATUS, 32'h00080000);
    rd(`OFF_STATUS, 32'h0);
    @(posedge clock) sources.device_ready <= 1'b1;
    rd(`OFF_STATUS, 32'h40000000);
    wr(`OFF_STATUS, 32'h40000000);
    rd(`OFF_STATUS, 32'h0);
    @(posedge clock) sources.power_event <= 1'b1;
    @(posedge clock) sources.power_event <= 1'b0;
    wr(`OFF_STATUS, 32'h00020000);
    rd(`OFF_STATUS, 32'h00020000);
    @(posedge clock) sources.power_clear_ok <= 1'b1;
    wr(`OFF_STATUS, 32'h00020000);
    rd(`OFF_STATUS, 32'h0);
    $display("test flags done");
    wr(`OFF_ENABLE, 32'h04020000);
    foreach (cfg_tab[k]) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge clock) sources.phy_a_pending <= s[0];
        wr(`OFF_PIN_CONFIG, cfg_tab[k]);
        repeat (3) @(posedge clock);
        check("pin", pin_level, exp_pin(cfg_tab[k], s[0]));
        check("global", global_irq, 32'(s));
        rd(`OFF_STATUS, 32'(s) << 26);
      end
    end
    deassert_hold <= 1'b1;
    wr(`OFF_PIN_CONFIG, 32'h111);
    repeat (3) @(posedge clock);
    check("held pin", pin_level, 32'h0);
    check("global", global_irq, 32'h1);
    @(posedge clock) sources.power_event <= 1'b1;
    @(posedge clock) sources.power_event <= 1'b0;
    repeat (2) @(posedge clock);
    check("held pin", pin_level, 32'h1);
    $display("test pin done");
    @(posedge clock) sources <= source_type'(9'h082);
    deassert_hold <= 1'b0;
    wr(`OFF_STATUS, 32'h00020000);
    repeat (3) @(posedge clock);
    check("masked pin", pin_level, 32'h0);
    check("global", global_irq, 32'h0);
    rd(`OFF_STATUS, 32'h10000000);
    $display("test mask done");
    @(posedge clock) clk_en <= 1'b0;
    @(posedge clock) sources.timer_wrap <= 1'b1;
    @(posedge clock) sources.timer_wrap <= 1'b0;
    wr(`OFF_ENABLE, 32'hffffffff);
    @(posedge clock) clk_en <= 1'b1;
    rd(`OFF_ENABLE, 32'h04020000);
    rd(`OFF_STATUS, 32'h10000000);
    $display("test freeze done");
    repeat (3) @(posedge clock);
    report_and_stop();
  end
endmodule

`default_nettype wire
